// ---- verilog/card_host_port.sv ----
// Summary of operation
// - Bit 0 is LSB of even byte, bit 8 LSB of odd byte.
// - Fixed-disk register accesses are bytes on the low eight lines only.
// - Fixed-disk sector data moves as full 16-bit words.
// - Input acknowledge asserts only while selected and answering an I/O read.
// - Memory mode never asserts input acknowledge.
// - Fixed-disk mode raises DMA request when ready to move data.
// - Read strobe moves data to host; write strobe moves it to device.
// - DMA request holds until acknowledge asserts, then drops.
// - DMA request reasserts while transfer data remains.
// - DMA request is not driven while the device is unselected.
module card_host_port (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Configuration
   input  wire card_port_pkg::port_mode_t     port_mode,
   input  wire logic                          device_selected,
   input  wire logic                          dma_enable,
   // Host strobes and selects (pins)
   input  wire logic                          io_read_strobe_n,
   input  wire logic                          io_write_strobe_n,
   input  wire logic                          register_select_0_n,
   input  wire logic                          register_select_1_n,
   input  wire logic                          dma_acknowledge_n,
   input  wire logic                          address_match,
   // Host data bus, split into three signals
   input  wire logic [card_port_pkg::DATA_W-1:0] host_data_bus_in,
   output logic      [card_port_pkg::DATA_W-1:0] host_data_bus_out,
   output logic                               host_data_bus_oe,
   // Handshake pins
   output logic                               input_ack_n,
   output logic                               dma_request_out,
   output logic                               dma_request_oe,
   // Register file side
   output logic                               reg_write,
   output logic                               reg_read,
   output logic      [card_port_pkg::BYTE_W-1:0] reg_wdata,
   input  wire logic [card_port_pkg::BYTE_W-1:0] reg_rdata,
   // Outgoing data stream (to host)
   input  wire logic                          tx_valid,
   output logic                               tx_ready,
   input  wire logic [card_port_pkg::DATA_W-1:0] tx_data,
   // Incoming data stream (from host)
   output logic                               rx_valid,
   input  wire logic                          rx_ready,
   output logic      [card_port_pkg::DATA_W-1:0] rx_data,
   // Remaining words in the current DMA transfer
   input  wire logic                          dma_more
);
   // Mode decode shared by request, read and acknowledge logic
   function automatic logic in_mode(input card_port_pkg::port_mode_t cur,
                                    input card_port_pkg::port_mode_t want);
      return cur == want;
   endfunction : in_mode

   logic [card_port_pkg::SYNC_W-1:0] sync1_ff;
   logic [card_port_pkg::SYNC_W-1:0] sync2_ff;
   logic [card_port_pkg::SYNC_W-1:0] prev_ff;
   logic [1:0]                       sel1_ff;
   logic [1:0]                       sel2_ff;
   logic                             am1_ff;
   logic                             am2_ff;
   logic [card_port_pkg::DATA_W-1:0] din1_ff;
   logic [card_port_pkg::DATA_W-1:0] din2_ff;
   logic                             rd_lvl;
   logic                             wr_lvl;
   logic                             ack_lvl;
   logic                             rd_rise;
   logic                             wr_rise;
   logic                             wr_fall;
   logic                             reg_sel;
   logic                             dma_cycle;
   card_port_pkg::dma_state_t        dma_state_ff;
   card_port_pkg::dma_state_t        nxt_dma_state;
   logic [card_port_pkg::DATA_W-1:0] dout_ff;
   logic                             oe_ff;
   logic                             inack_ff;
   logic                             rd_pending_ff;
   logic                             fifo_in_valid;
   logic                             fifo_in_ready;

   // Strobe and acknowledge synchronisers; idle high so no false edge after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= card_port_pkg::SYNC_IDLE;
         sync2_ff <= card_port_pkg::SYNC_IDLE;
         prev_ff  <= card_port_pkg::SYNC_IDLE;
      end else begin
         sync1_ff <= {dma_acknowledge_n, io_write_strobe_n, io_read_strobe_n};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // Register selects and address match, same two-stage delay as the strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         sel1_ff <= '1;
         sel2_ff <= '1;
         am1_ff  <= 1'b0;
         am2_ff  <= 1'b0;
      end else begin
         sel1_ff <= {register_select_1_n, register_select_0_n};
         sel2_ff <= sel1_ff;
         am1_ff  <= address_match;
         am2_ff  <= am1_ff;
      end
   end

   // Data lines; host holds them past the strobe so the word is settled here
   always_ff @(posedge clk) begin
      if (rst) begin
         din1_ff <= card_port_pkg::DATA_RST;
         din2_ff <= card_port_pkg::DATA_RST;
      end else begin
         din1_ff <= host_data_bus_in;
         din2_ff <= din1_ff;
      end
   end

   // Active-high levels and edges of the clean strobes
   assign rd_lvl  = !sync2_ff[card_port_pkg::SYNC_RD];
   assign wr_lvl  = !sync2_ff[card_port_pkg::SYNC_WR];
   assign ack_lvl = !sync2_ff[card_port_pkg::SYNC_ACK];
   assign rd_rise = rd_lvl && prev_ff[card_port_pkg::SYNC_RD];
   assign wr_rise = wr_lvl && prev_ff[card_port_pkg::SYNC_WR];
   assign wr_fall = !wr_lvl && !prev_ff[card_port_pkg::SYNC_WR];
   assign reg_sel = device_selected && (sel2_ff != 2'h3) && !ack_lvl;
   // Data cycles only under acknowledge, which excludes register selects
   assign dma_cycle = device_selected && ack_lvl
                      && in_mode(port_mode, card_port_pkg::MODE_DISK);

   // DMA handshake next state
   always_comb begin
      nxt_dma_state = dma_state_ff;
      case (dma_state_ff)
         card_port_pkg::DMA_IDLE: begin
            if (dma_enable && dma_more && in_mode(port_mode, card_port_pkg::MODE_DISK)) begin
               nxt_dma_state = card_port_pkg::DMA_REQ;
            end
         end
         card_port_pkg::DMA_REQ: begin
            if (ack_lvl) begin
               nxt_dma_state = card_port_pkg::DMA_XFER;
            end
         end
         card_port_pkg::DMA_XFER: begin
            if (!ack_lvl) begin
               // Re-request while words remain
               nxt_dma_state = (dma_enable && dma_more) ? card_port_pkg::DMA_REQ
                                                        : card_port_pkg::DMA_IDLE;
            end
         end
         default: nxt_dma_state = card_port_pkg::DMA_IDLE;
      endcase
   end

   // DMA handshake state register
   always_ff @(posedge clk) begin
      if (rst) begin
         dma_state_ff <= card_port_pkg::DMA_IDLE;
      end else begin
         dma_state_ff <= nxt_dma_state;
      end
   end

   // Request pin floats when another device is selected
   assign dma_request_out = (dma_state_ff == card_port_pkg::DMA_REQ);
   assign dma_request_oe  = device_selected
                            && in_mode(port_mode, card_port_pkg::MODE_DISK);

   // Read data path: registers byte-wide, data words full width
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_ff       <= card_port_pkg::DATA_RST;
         oe_ff         <= 1'b0;
         rd_pending_ff <= 1'b0;
      end else begin
         rd_pending_ff <= 1'b0;
         if (!rd_lvl) begin
            oe_ff <= 1'b0;
         end else if (rd_rise && reg_sel && port_mode != card_port_pkg::MODE_MEMORY) begin
            // Upper byte zero, bit 0 is even-byte LSB
            dout_ff <= {card_port_pkg::BYTE_ZERO, reg_rdata};
            oe_ff   <= 1'b1;
         end else if (rd_rise && dma_cycle && tx_valid) begin
            dout_ff       <= tx_data;
            oe_ff         <= 1'b1;
            rd_pending_ff <= 1'b1;
         end
      end
   end

   assign host_data_bus_out = dout_ff;
   assign host_data_bus_oe  = oe_ff;
   assign tx_ready          = rd_pending_ff;
   assign reg_read          = rd_rise && reg_sel;

   // Input acknowledge only for selected I/O-mode reads at our address
   always_ff @(posedge clk) begin
      if (rst) begin
         inack_ff <= 1'b0;
      end else begin
         inack_ff <= in_mode(port_mode, card_port_pkg::MODE_IO)
                     && reg_sel && rd_lvl && am2_ff;
      end
   end

   assign input_ack_n = !inack_ff;

   // Register writes carry only the low byte
   assign reg_write = wr_rise && reg_sel;
   assign reg_wdata = din2_ff[card_port_pkg::BYTE_W-1:0];

   // Host writes are captured as full words at strobe release
   assign fifo_in_valid = wr_fall && dma_cycle;

   // Receive buffer; words arriving while it is full are dropped, as the request ignores buffer space
   word_fifo #(
      .WIDTH (card_port_pkg::DATA_W),
      .DEPTH (card_port_pkg::FIFO_DEPTH)
   ) rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (din2_ff),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );
endmodule : card_host_port

// Word buffer between host writes and the sink
// A full buffer refuses new words and never overwrites stored ones
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int          AW         = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH-1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   // Full and empty straight from the occupancy count
   assign in_ready  = (count_ff != FULL_COUNT);
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and occupancy; extra count bit tells full from empty
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule : word_fifo

// ---- verilog/card_port_pkg.sv ----
package card_port_pkg;
   // Operating modes of the host port
   typedef enum logic [1:0] {
      MODE_MEMORY = 2'h0,
      MODE_IO     = 2'h1,
      MODE_DISK   = 2'h2
   } port_mode_t;

   // DMA handshake states, one-hot
   typedef enum logic [2:0] {
      DMA_IDLE = 3'h1,
      DMA_REQ  = 3'h2,
      DMA_XFER = 3'h4
   } dma_state_t;

   localparam int DATA_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int SYNC_W     = 3;
   localparam int SYNC_RD    = 0;
   localparam int SYNC_WR    = 1;
   localparam int SYNC_ACK   = 2;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h7;
   localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage : card_port_pkg

// ---- verilog/word_fifo.sv ----
// Receive buffer module sits beside the port logic in card_host_port.sv

// ---- sim/card_host_port_props.sv ----
module card_host_port_props (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // Watched ports
   input wire card_port_pkg::port_mode_t port_mode,
   input wire logic                      device_selected,
   input wire logic                      dma_enable,
   input wire logic                      dma_more,
   input wire logic                      io_read_strobe_n,
   input wire logic                      dma_acknowledge_n,
   input wire logic                      host_data_bus_oe,
   input wire logic                      input_ack_n,
   input wire logic                      dma_request_out,
   input wire logic                      dma_request_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Acknowledge quiet in memory mode; acknowledge and bus drive need a recent read strobe
   a_ack_mem_quiet: assert property (
      (port_mode == card_port_pkg::MODE_MEMORY) [*4] |-> input_ack_n) else $error("ack in mem");
   a_ack_no_read: assert property (
      io_read_strobe_n [*5] |-> input_ack_n) else $error("ack without read");
   a_oe_no_read: assert property (
      io_read_strobe_n [*5] |-> !host_data_bus_oe) else $error("drive without read");
   a_oe_after_read: assert property (
      $rose(host_data_bus_oe) |-> !$past(io_read_strobe_n, 2) || !$past(io_read_strobe_n, 3))
      else $error("drive not from read");
   // Request handshake; stale sync stages are why ack must be high 3 cycles
   a_req_sel_only: assert property (
      dma_request_oe |-> device_selected && port_mode == card_port_pkg::MODE_DISK)
      else $error("request driven unselected");
   a_req_hold_ack: assert property (
      dma_request_out && dma_acknowledge_n && $past(dma_acknowledge_n, 3) && dma_enable
      && device_selected && port_mode == card_port_pkg::MODE_DISK |=> dma_request_out)
      else $error("request dropped early");
   a_req_drop_ack: assert property (
      dma_request_out && !dma_acknowledge_n |-> ##[1:4] !dma_request_out)
      else $error("request held after ack");
   a_req_again: assert property (
      $rose(dma_acknowledge_n) && dma_more && dma_enable && device_selected
      && port_mode == card_port_pkg::MODE_DISK |-> ##[1:6] dma_request_out)
      else $error("request not renewed");
endmodule : card_host_port_props

bind card_host_port card_host_port_props i_props (.clk, .rst, .port_mode, .device_selected,
   .dma_enable, .dma_more, .io_read_strobe_n, .dma_acknowledge_n, .host_data_bus_oe,
   .input_ack_n, .dma_request_out, .dma_request_oe);

// ---- sim/host_model.sv ----
module host_model #(
   parameter int W = card_port_pkg::DATA_W
) (
   // Clock
   input wire logic         clk,
   // Strobes, selects and acknowledge; this host has DMA, request watched by bench
   output logic             io_read_strobe_n,
   output logic             io_write_strobe_n,
   output logic             register_select_0_n,
   output logic             register_select_1_n,
   output logic             dma_acknowledge_n,
   // Data bus wire, resolved here
   output logic [W-1:0]     host_data_bus_in,
   input wire logic [W-1:0] host_data_bus_out,
   input wire logic         host_data_bus_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic         drv = 1'b0;
   logic [W-1:0] wval = '0;
   logic [W-1:0] last = '0;
   // All pins idle high
   initial {io_read_strobe_n, io_write_strobe_n, register_select_0_n, register_select_1_n,
      dma_acknowledge_n} = 5'h1F;
   // Floating wire toggles so stale data never looks valid
   always_comb host_data_bus_in = drv ? wval : (host_data_bus_oe ? host_data_bus_out : ~last);
   always @(posedge clk) last <= host_data_bus_in;
   // Acknowledge level, set just after an edge
   task automatic ack(input logic v);
      @(posedge clk);
      #1 dma_acknowledge_n = v;
   endtask : ack
   // One strobe cycle; write data held past release since it is taken there
   task automatic cycle(input logic wr, input logic sel, input logic [W-1:0] d,
                        input int hold, output logic [W-1:0] q);
      @(posedge clk);
      #1 register_select_0_n = !sel;
      wval = d;
      drv = wr;
      io_write_strobe_n = !wr;
      io_read_strobe_n = wr;
      repeat (hold) @(posedge clk);
      q = host_data_bus_in;
      #1 io_write_strobe_n = 1'b1;
      io_read_strobe_n = 1'b1;
      register_select_0_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 drv = 1'b0;
   endtask : cycle
endmodule : host_model

// ---- sim/card_host_port_tb.sv ----
module card_host_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W = card_port_pkg::DATA_W;
   // Bench inputs
   logic clk = 1'b0;
   logic rst = 1'b1;
   card_port_pkg::port_mode_t port_mode = card_port_pkg::MODE_MEMORY;
   logic device_selected = 1'b1, dma_enable = 1'b0, address_match = 1'b1, dma_more = 1'b0;
   logic tx_valid = 1'b0, rx_ready = 1'b0;
   logic [7:0] reg_rdata = 8'h00;
   logic [W-1:0] tx_data = '0;
   // Pins, outputs and bench state
   logic io_read_strobe_n, io_write_strobe_n, register_select_0_n, register_select_1_n;
   logic dma_acknowledge_n, host_data_bus_oe, input_ack_n, dma_request_out, dma_request_oe;
   logic reg_write, rx_valid, ack_seen, rd;
   logic [7:0] reg_wdata, wseen;
   logic [W-1:0] host_data_bus_in, host_data_bus_out, rx_data, d, q;
   logic [W-1:0] exp_q[$];
   int mismatches = 0, checks_done = 0;
   always #20 clk = ~clk;
   card_host_port i_dut (.clk, .rst, .port_mode, .device_selected, .dma_enable,
      .io_read_strobe_n, .io_write_strobe_n, .register_select_0_n, .register_select_1_n,
      .dma_acknowledge_n, .address_match, .host_data_bus_in, .host_data_bus_out,
      .host_data_bus_oe, .input_ack_n, .dma_request_out, .dma_request_oe, .reg_write,
      .reg_read(), .reg_wdata, .reg_rdata, .tx_valid, .tx_ready(), .tx_data, .rx_valid,
      .rx_ready, .rx_data, .dma_more);
   host_model i_host (.clk, .io_read_strobe_n, .io_write_strobe_n, .register_select_0_n,
      .register_select_1_n, .dma_acknowledge_n, .host_data_bus_in, .host_data_bus_out,
      .host_data_bus_oe);
   // Sticky acknowledge as a host buffer enable sees it, last register byte
   always @(negedge clk) begin
      if (input_ack_n === 1'b0) ack_seen = 1'b1;
      if (reg_write === 1'b1) wseen = reg_wdata;
   end
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait for a request level
   task automatic wait_req(input logic v);
      for (int n = 0; dma_request_out !== v; n++) begin
         if (n == 60) begin
            mismatches++;
            final_report();
         end
         @(posedge clk);
      end
   endtask : wait_req
   task automatic final_report();
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(32'h06690394));
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      // Memory mode, then I/O mode off and on the address
      ack_seen = 1'b0;
      i_host.cycle(1'b0, 1'b1, '0, 6, q);
      check(W'(ack_seen), '0);
      port_mode = card_port_pkg::MODE_IO;
      for (int m = 0; m < 2; m++) begin
         address_match = m[0];
         ack_seen = 1'b0;
         i_host.cycle(1'b0, 1'b1, '0, 6, q);
         check(W'(ack_seen), W'(m));
      end
      // Register bytes only on the low lines
      port_mode = card_port_pkg::MODE_DISK;
      repeat (4) begin
         d = W'($urandom);
         reg_rdata = d[15:8];
         wseen = 'x;
         i_host.cycle(1'b0, 1'b1, '0, $urandom_range(9, 5), q);
         check(q, {8'h00, d[15:8]});
         i_host.cycle(1'b1, 1'b1, d, 6, q);
         check(W'(wseen), W'(d[7:0]));
      end
      // DMA words, reads alternating with writes for eight, then writes past the buffer depth
      dma_enable = 1'b1;
      dma_more = 1'b1;
      tx_valid = 1'b1;
      for (int k = 0; k < 40; k++) begin
         d = W'($urandom);
         tx_data = d;
         rd = (k < 8) && !k[0];
         wait_req(1'b1);
         i_host.ack(1'b0);
         wait_req(1'b0);
         i_host.cycle(!rd, 1'b0, d, $urandom_range(9, 5), q);
         if (rd) check(q, d);
         else if (exp_q.size() < card_port_pkg::FIFO_DEPTH) exp_q.push_back(d);
         if (k == 39) dma_more = 1'b0;
         i_host.ack(1'b1);
      end
      repeat (8) @(posedge clk);
      check(W'(dma_request_out), '0);
      #1 rx_ready = 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         if (rx_valid === 1'b1) check(rx_data, exp_q.size() ? exp_q.pop_front() : ~rx_data);
      end
      check(W'(exp_q.size()), '0);
      @(posedge clk);
      #1 device_selected = 1'b0;
      dma_more = 1'b1;
      repeat (4) @(posedge clk);
      check(W'(dma_request_oe), '0);
      final_report();
   end
endmodule : card_host_port_tb
